/* File: hdl/lcd_controller_fifo_reset.sv */
// lcd controller dma fifo with completion flush and per-domain software resets
// assumes a same-clock memory source for dma words and software on the register port
// Operation
// - when an async panel dma transfer completes, dma enable clears and both fifo pointers reset.
// - every finished dma transfer sets the done flag of the raw interrupt status.
// - writing one to the dma and panel-interface reset bits resets those domains and both fifo pointers.
// - while the main or panel-interface software reset is held the panel control outputs sit at the controller default levels.
// - the underflow auto restart bit is stored but has no effect; recovery is by software reset.
// - once raster enable is cleared and raster output has stopped, the done flag is raised.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module lcd_controller_fifo_reset
    import lcd_fifo_reset_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [DATA_W-1:0] reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic [DATA_W-1:0]      reg_rdata_out,
    output logic                   irq_out,
    output logic                   dma_req_out,
    input  wire logic              dma_valid_in,
    input  wire logic [DATA_W-1:0] dma_data_in,
    output logic                   panel_cs_n_out,
    output logic                   panel_we_n_out,
    output logic [DATA_W-1:0]      panel_data_out,
    output logic                   pixel_valid_out
);
    localparam int PTR_W = $clog2(DEPTH) + 1;

    logic                raster_en;
    logic                uflow_restart;
    logic [RST_W-1:0]    rst_bits;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic [LEN_W-1:0]    dma_length;
    logic [DATA_W-1:0]   rdata;
    logic                next_raster_en;
    logic                next_uflow_restart;
    logic [RST_W-1:0]    next_rst_bits;
    logic [STATUS_W-1:0] next_status;
    logic [STATUS_W-1:0] next_mask;
    logic [LEN_W-1:0]    next_dma_length;
    logic [DATA_W-1:0]   next_rdata;

    logic                dma_en;
    logic [LEN_W-1:0]    remaining;
    logic                next_dma_en;
    logic [LEN_W-1:0]    next_remaining;
    logic                raster_active;
    logic                next_raster_active;
    logic                cs_n;
    logic                we_n;
    logic [DATA_W-1:0]   pdata;
    logic                pvalid;
    logic                next_cs_n;
    logic                next_we_n;
    logic [DATA_W-1:0]   next_pdata;
    logic                next_pvalid;

    logic                dma_dom_rst;
    logic                panel_dom_rst;
    logic                core_dom_rst;
    logic                dma_done;
    logic                raster_done;
    logic                raster_uflow;
    logic                flush;
    logic                push_ready;
    logic                push_valid;
    logic                pop;
    logic                pop_valid;
    logic [DATA_W-1:0]   pop_data;
    logic [PTR_W-1:0]    wr_ptr;
    logic [PTR_W-1:0]    rd_ptr;
    logic                wr_hit;
    logic [STATUS_W-1:0] events;

    // domains stay in reset as long as their bit reads one
    assign dma_dom_rst   = rst_in || rst_bits[BIT_MAIN_RST] || rst_bits[BIT_DMA_RST];
    assign panel_dom_rst = rst_in || rst_bits[BIT_MAIN_RST] || rst_bits[BIT_PANEL_RST];
    assign core_dom_rst  = rst_in || rst_bits[BIT_MAIN_RST] || rst_bits[BIT_CORE_RST];

    // transfer ends once every word is fetched and the fifo has drained to the panel
    assign dma_done     = dma_en && (remaining == '0) && !pop_valid;
    assign flush        = dma_done || dma_dom_rst || panel_dom_rst;
    assign dma_req_out  = dma_en && (remaining != '0) && push_ready;
    assign push_valid   = dma_req_out && dma_valid_in;
    assign pop          = !panel_dom_rst && pop_valid && (dma_en || raster_active);
    // the restart bit feeds nothing here: underflow only reports, software recovers
    assign raster_uflow = raster_active && !dma_en && !pop_valid;
    assign raster_done  = raster_active && !next_raster_active;
    assign events       = {raster_uflow, dma_done || raster_done};
    assign wr_hit       = reg_wr_in && (reg_addr_in == OFS_ASYNC_CTRL);
    assign irq_out      = |(status & mask);

    lcd_fifo_store #(
        .WIDTH (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_sys_in     (clk_sys_in),
        .flush_in       (flush),
        .push_valid_in  (push_valid),
        .push_ready_out (push_ready),
        .push_data_in   (dma_data_in),
        .pop_in         (pop),
        .pop_valid_out  (pop_valid),
        .pop_data_out   (pop_data),
        .wr_ptr_out     (wr_ptr),
        .rd_ptr_out     (rd_ptr)
    );

    // register file, reset only by the system reset
    always_comb begin
        next_raster_en     = raster_en;
        next_uflow_restart = uflow_restart;
        next_rst_bits      = rst_bits;
        next_mask          = mask;
        next_dma_length    = dma_length;
        next_status        = status;
        next_rdata         = '0;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_RASTER_CTRL: begin
                    next_raster_en     = reg_wdata_in[BIT_RASTER_EN];
                    next_uflow_restart = reg_wdata_in[BIT_UFLOW_RESTART];
                end
                OFS_DOMAIN_RST: next_rst_bits = reg_wdata_in[RST_W-1:0];
                OFS_IRQ_MASK:   next_mask = reg_wdata_in[STATUS_W-1:0];
                OFS_DMA_LENGTH: next_dma_length = reg_wdata_in[LEN_W-1:0];
                OFS_RAW_STATUS: next_status = status & ~reg_wdata_in[STATUS_W-1:0];
                default: ;
            endcase
        end
        // a new event outweighs a clear in the same cycle
        next_status = next_status | events;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_ASYNC_CTRL:  next_rdata[BIT_DMA_EN] = dma_en;
                OFS_RASTER_CTRL: begin
                    next_rdata[BIT_RASTER_EN]     = raster_en;
                    next_rdata[BIT_UFLOW_RESTART] = uflow_restart;
                end
                OFS_DOMAIN_RST:  next_rdata[RST_W-1:0] = rst_bits;
                OFS_RAW_STATUS:  next_rdata[STATUS_W-1:0] = status;
                OFS_IRQ_MASK:    next_rdata[STATUS_W-1:0] = mask;
                OFS_DMA_LENGTH:  next_rdata[LEN_W-1:0] = dma_length;
                OFS_FIFO_STATE: begin
                    next_rdata[LSB_WR_PTR +: PTR_W] = wr_ptr;
                    next_rdata[LSB_RD_PTR +: PTR_W] = rd_ptr;
                    next_rdata[BIT_EMPTY]           = !pop_valid;
                    next_rdata[BIT_FULL]            = !push_ready;
                end
                default: ;
            endcase
        end
        if (rst_in) begin
            next_raster_en     = 1'b0;
            next_uflow_restart = 1'b0;
            next_rst_bits      = RST_BITS_RESET;
            next_mask          = STATUS_RESET;
            next_dma_length    = LENGTH_RESET;
            next_status        = STATUS_RESET;
            next_rdata         = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        raster_en     <= next_raster_en;
        uflow_restart <= next_uflow_restart;
        rst_bits      <= next_rst_bits;
        mask          <= next_mask;
        dma_length    <= next_dma_length;
        status        <= next_status;
        rdata         <= next_rdata;
    end

    assign reg_rdata_out = rdata;

    // dma domain
    always_comb begin
        next_dma_en    = dma_en;
        next_remaining = remaining;
        if (wr_hit) begin
            next_dma_en    = reg_wdata_in[BIT_DMA_EN];
            next_remaining = dma_length;
        end else if (dma_done) begin
            next_dma_en = 1'b0;
        end else if (push_valid) begin
            next_remaining = remaining - 1'b1;
        end
        if (dma_dom_rst) begin
            next_dma_en    = 1'b0;
            next_remaining = '0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        dma_en    <= next_dma_en;
        remaining <= next_remaining;
    end

    // core domain: raster stops one cycle after enable drops
    always_comb begin
        next_raster_active = raster_en && !core_dom_rst;
    end

    always_ff @(posedge clk_sys_in) begin
        raster_active <= next_raster_active;
    end

    // panel domain
    always_comb begin
        next_cs_n   = dma_en ? CS_N_ACTIVE : CS_N_IDLE;
        next_we_n   = WE_N_IDLE;
        next_pdata  = pdata;
        next_pvalid = 1'b0;
        if (pop) begin
            next_pdata  = pop_data;
            next_we_n   = dma_en ? WE_N_ACTIVE : WE_N_IDLE;
            next_pvalid = !dma_en;
        end
        if (panel_dom_rst) begin
            // default levels, which a panel of opposite polarity sees as active
            next_cs_n   = CS_N_IDLE;
            next_we_n   = WE_N_IDLE;
            next_pdata  = '0;
            next_pvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        cs_n   <= next_cs_n;
        we_n   <= next_we_n;
        pdata  <= next_pdata;
        pvalid <= next_pvalid;
    end

    assign panel_cs_n_out  = cs_n;
    assign panel_we_n_out  = we_n;
    assign panel_data_out  = pdata;
    assign pixel_valid_out = pvalid;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence raster_stop_s;
        raster_active && !raster_en ##1 !raster_active;
    endsequence

    sequence reset_held_s;
        rst_bits[BIT_DMA_RST] [*2];
    endsequence

    dma_end_flush_a: assert property (dma_done |=> !dma_en && wr_ptr == '0 && rd_ptr == '0)
        else $error("dma completion did not clear enable and both pointers");
    dma_end_done_a: assert property (dma_done && !rst_bits[BIT_MAIN_RST] |=> status[BIT_DONE])
        else $error("dma completion did not set done");
    set_wins_a: assert property (events[BIT_DONE] && reg_wr_in && reg_addr_in == OFS_RAW_STATUS
        |=> status[BIT_DONE])
        else $error("done event lost to a clear");
    sw_reset_ptrs_a: assert property ((rst_bits[BIT_DMA_RST] || rst_bits[BIT_PANEL_RST])
        |=> wr_ptr == '0 && rd_ptr == '0)
        else $error("software reset left a fifo pointer");
    idle_strobes_a: assert property (panel_dom_rst |=> panel_cs_n_out == CS_N_IDLE
        && panel_we_n_out == WE_N_IDLE && !pixel_valid_out)
        else $error("panel strobes not at default during reset");
    // an underflow with the restart bit set must neither flush nor stop reporting
    no_auto_restart_a: assert property (raster_uflow && uflow_restart && !flush
        |=> $stable(wr_ptr) && $stable(rd_ptr) && status[BIT_UFLOW])
        else $error("underflow restart bit triggered a hardware recovery");
    raster_done_a: assert property (raster_stop_s |-> status[BIT_DONE])
        else $error("raster stop did not raise done");
    reset_level_a: assert property (reset_held_s |-> !dma_en && !dma_req_out && wr_ptr == '0)
        else $error("dma domain ran while its reset bit was set");
    read_window_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
        else $error("read data outside the read answer cycle");
endmodule

/* File: hdl/lcd_fifo_reset_pkg.sv */
// constants shared by the lcd controller fifo recovery logic
// assumes a 32-bit plain register port with byte-address offsets
package lcd_fifo_reset_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LEN_W  = 16;

    localparam logic [ADDR_W-1:0] OFS_ASYNC_CTRL  = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_RASTER_CTRL = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DOMAIN_RST  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_RAW_STATUS  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK    = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_DMA_LENGTH  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_FIFO_STATE  = 8'h18;

    // async_panel_control
    localparam int BIT_DMA_EN        = 0;
    // raster control
    localparam int BIT_RASTER_EN     = 0;
    localparam int BIT_UFLOW_RESTART = 1;
    // domain_reset_control
    localparam int RST_W             = 4;
    localparam int BIT_MAIN_RST      = 0;
    localparam int BIT_CORE_RST      = 1;
    localparam int BIT_DMA_RST       = 2;
    localparam int BIT_PANEL_RST     = 3;
    // raw_interrupt_status and mask
    localparam int STATUS_W          = 2;
    localparam int BIT_DONE          = 0;
    localparam int BIT_UFLOW         = 1;
    // fifo state readback
    localparam int PTR_FIELD_W       = 8;
    localparam int LSB_WR_PTR        = 0;
    localparam int LSB_RD_PTR        = 8;
    localparam int BIT_EMPTY         = 16;
    localparam int BIT_FULL          = 17;

    localparam logic [RST_W-1:0]    RST_BITS_RESET = 4'h0;
    localparam logic [STATUS_W-1:0] STATUS_RESET   = 2'h0;
    localparam logic [LEN_W-1:0]    LENGTH_RESET   = 16'h0000;

    // controller default and active levels of the panel strobes
    localparam logic CS_N_IDLE   = 1'b1;
    localparam logic CS_N_ACTIVE = 1'b0;
    localparam logic WE_N_IDLE   = 1'b1;
    localparam logic WE_N_ACTIVE = 1'b0;
endpackage

/* File: hdl/lcd_fifo_store.sv */
// word fifo between the dma side and the panel side of the lcd controller
// assumes one clock; flush_in clears both pointers and beats push and pop
`timescale 1ns/100ps
module lcd_fifo_store
    import lcd_fifo_reset_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    localparam int PTR_W = $clog2(DEPTH) + 1
) (
    input  wire logic             clk_sys_in,
    input  wire logic             flush_in,
    input  wire logic             push_valid_in,
    output logic                  push_ready_out,
    input  wire logic [WIDTH-1:0] push_data_in,
    input  wire logic             pop_in,
    output logic                  pop_valid_out,
    output logic [WIDTH-1:0]      pop_data_out,
    output logic [PTR_W-1:0]      wr_ptr_out,
    output logic [PTR_W-1:0]      rd_ptr_out
);
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || PTR_W > PTR_FIELD_W) begin : g_bad_depth
            $error("fifo depth must be a power of two from 2 to 128");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic             empty;
    logic             full;
    logic             do_push;

    assign empty          = (wr_ptr == rd_ptr);
    assign full           = (wr_ptr[PTR_W-1] != rd_ptr[PTR_W-1]) && (wr_ptr[PTR_W-2:0] == rd_ptr[PTR_W-2:0]);
    assign push_ready_out = !full;
    assign pop_valid_out  = !empty;
    assign pop_data_out   = mem[rd_ptr[PTR_W-2:0]];
    assign wr_ptr_out     = wr_ptr;
    assign rd_ptr_out     = rd_ptr;
    assign do_push        = push_valid_in && !full && !flush_in;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (flush_in) begin
            // both pointers together, never just the write side
            next_wr_ptr = '0;
            next_rd_ptr = '0;
        end else begin
            if (do_push) begin
                next_wr_ptr = wr_ptr + 1'b1;
            end
            if (pop_in && !empty) begin
                next_rd_ptr = rd_ptr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        wr_ptr <= next_wr_ptr;
        rd_ptr <= next_rd_ptr;
        if (do_push) begin
            mem[wr_ptr[PTR_W-2:0]] <= push_data_in;
        end
    end
endmodule

/* File: verif/lcd_panel_model.sv */
// far side of the lcd controller: dma word source plus async panel receiver
// assumes one clock; the bench drives clear/slow/limit by nba after a rising edge
`timescale 1ns/100ps
module lcd_panel_model
    import lcd_fifo_reset_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              clear_in,
    input  wire logic              slow_in,
    input  wire logic [7:0]        limit_in,
    input  wire logic              dma_req_in,
    output logic                   dma_valid_out,
    output logic [DATA_W-1:0]      dma_data_out,
    input  wire logic              panel_cs_n_in,
    input  wire logic              panel_we_n_in,
    input  wire logic [DATA_W-1:0] panel_data_in,
    output logic [7:0]             words_seen_out,
    output logic                   order_ok_out
);
    logic [7:0]        idx;
    logic              phase;
    logic [DATA_W-1:0] last_word;

    // slow mode offers a word only every other cycle
    assign dma_valid_out = (idx < limit_in) && (!slow_in || phase);
    // idle source shows the inverse of its last word so stale data never looks good
    assign dma_data_out  = dma_valid_out ? (32'ha5a50000 | DATA_W'(idx)) : ~last_word;

    always_ff @(posedge clk_sys_in) begin
        phase <= clear_in ? 1'b0 : ~phase;
        if (clear_in) begin
            idx            <= 8'h00;
            words_seen_out <= 8'h00;
            order_ok_out   <= 1'b1;
            last_word      <= 32'h00000000;
        end else begin
            if (dma_req_in && dma_valid_out) begin
                idx       <= idx + 8'h01;
                last_word <= dma_data_out;
            end
            if (!panel_cs_n_in && !panel_we_n_in) begin
                words_seen_out <= words_seen_out + 8'h01;
                if (panel_data_in !== (32'ha5a50000 | DATA_W'(words_seen_out))) begin
                    order_ok_out <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: verif/tb.sv */
// self-checking bench for the lcd fifo recovery block
// assumes the panel model file is compiled first
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb;
    import lcd_fifo_reset_pkg::*;
    logic              clk_sys_in, rst_in, reg_wr_in, reg_rd_in, irq_out, dma_req_out, dma_valid_in;
    logic [ADDR_W-1:0] reg_addr_in;
    logic [DATA_W-1:0] reg_wdata_in, reg_rdata_out, dma_data_in, panel_data_out, d;
    logic              panel_cs_n_out, panel_we_n_out, pixel_valid_out, clear, slow, order_ok;
    logic [7:0]        limit, words_seen;
    int                n_mismatch = 0;
    int                check_count = 0;
    localparam logic [DATA_W-1:0] EMPTY = DATA_W'(1) << BIT_EMPTY;

    lcd_controller_fifo_reset #(.DEPTH(16)) u_lcd_controller_fifo_reset (.clk_sys_in(clk_sys_in),
        .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out), .dma_req_out(dma_req_out),
        .dma_valid_in(dma_valid_in), .dma_data_in(dma_data_in), .panel_cs_n_out(panel_cs_n_out),
        .panel_we_n_out(panel_we_n_out), .panel_data_out(panel_data_out), .pixel_valid_out(pixel_valid_out));
    lcd_panel_model u_lcd_panel_model (.clk_sys_in(clk_sys_in), .clear_in(clear), .slow_in(slow),
        .limit_in(limit), .dma_req_in(dma_req_out), .dma_valid_out(dma_valid_in), .dma_data_out(dma_data_in),
        .panel_cs_n_in(panel_cs_n_out), .panel_we_n_in(panel_we_n_out), .panel_data_in(panel_data_out),
        .words_seen_out(words_seen), .order_ok_out(order_ok));

    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_sys_in);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask

    task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        rd(a);
        `CHK(d, v)
    endtask

    // bounded poll; a done flag that never comes shows up as one mismatch
    task automatic wait_done(input int lim);
        for (int i = 0; i < lim; i++) begin
            rd(OFS_RAW_STATUS);
            if (d[BIT_DONE] === 1'b1) break;
        end
        `CHK(d[BIT_DONE], 1'b1)
    endtask

    task automatic chk_idle();
        `CHK(panel_cs_n_out, CS_N_IDLE)
        `CHK(panel_we_n_out, WE_N_IDLE)
        `CHK(pixel_valid_out, 1'b0)
        `CHK(panel_data_out, 32'h00000000)
    endtask

    task automatic model_clear(input logic [7:0] lim, input logic sl);
        @(posedge clk_sys_in);
        clear <= 1'b1;
        limit <= lim;
        slow  <= sl;
        @(posedge clk_sys_in);
        clear <= 1'b0;
    endtask

    task automatic test_reset_values();
        for (int a = 0; a < 8'h18; a += 4) chk_reg(ADDR_W'(a), 32'h00000000);
        chk_reg(OFS_FIFO_STATE, EMPTY);
        chk_reg(8'h1c, 32'h00000000);
        chk_idle();
        `CHK(irq_out, 1'b0)
        $display("test reset_values done");
    endtask

    task automatic test_dma_done();
        model_clear(8'hff, 1'b1);
        wr(OFS_DMA_LENGTH, 32'h00000005);
        wr(OFS_ASYNC_CTRL, 32'h00000001);
        wait_done(100);
        chk_reg(OFS_ASYNC_CTRL, 32'h00000000);
        chk_reg(OFS_FIFO_STATE, EMPTY);
        `CHK(words_seen, 8'h05)
        `CHK(order_ok, 1'b1)
        `CHK(irq_out, 1'b0)
        wr(OFS_IRQ_MASK, 32'h00000001);
        `CHK(irq_out, 1'b1)
        wr(OFS_RAW_STATUS, 32'h00000001);
        `CHK(irq_out, 1'b0)
        chk_reg(OFS_RAW_STATUS, 32'h00000000);
        // zero length finishes at once
        wr(OFS_DMA_LENGTH, 32'h00000000);
        wr(OFS_ASYNC_CTRL, 32'h00000001);
        wait_done(10);
        chk_reg(OFS_ASYNC_CTRL, 32'h00000000);
        wr(OFS_RAW_STATUS, 32'h00000003);
        $display("test dma_done done");
    endtask

    task automatic test_soft_reset();
        model_clear(8'h02, 1'b0);
        wr(OFS_DMA_LENGTH, 32'h00000008);
        wr(OFS_ASYNC_CTRL, 32'h00000001);
        repeat (10) @(posedge clk_sys_in);
        chk_reg(OFS_FIFO_STATE, EMPTY | 32'h00000202);
        `CHK(words_seen, 8'h02)
        `CHK(panel_cs_n_out, CS_N_ACTIVE)
        wr(OFS_DOMAIN_RST, DATA_W'((1 << BIT_DMA_RST) | (1 << BIT_PANEL_RST)));
        repeat (6) begin
            @(posedge clk_sys_in);
            #1 chk_idle();
        end
        chk_reg(OFS_FIFO_STATE, EMPTY);
        wr(OFS_ASYNC_CTRL, 32'h00000001);
        chk_reg(OFS_ASYNC_CTRL, 32'h00000000);
        `CHK(dma_req_out, 1'b0)
        wr(OFS_DOMAIN_RST, 32'h00000000);
        chk_reg(OFS_FIFO_STATE, EMPTY);
        chk_reg(OFS_DOMAIN_RST, 32'h00000000);
        `CHK(panel_cs_n_out, CS_N_IDLE)
        wr(OFS_RAW_STATUS, 32'h00000003);
        $display("test soft_reset done");
    endtask

    task automatic test_raster_recovery();
        wr(OFS_RASTER_CTRL, DATA_W'((1 << BIT_RASTER_EN) | (1 << BIT_UFLOW_RESTART)));
        repeat (4) @(posedge clk_sys_in);
        rd(OFS_RAW_STATUS);
        `CHK(d[BIT_UFLOW], 1'b1)
        chk_reg(OFS_RASTER_CTRL, 32'h00000003);
        wr(OFS_RAW_STATUS, 32'h00000003);
        wr(OFS_RASTER_CTRL, 32'h00000000);
        wait_done(10);
        wr(OFS_RAW_STATUS, 32'h00000003);
        repeat (3) @(posedge clk_sys_in);
        chk_reg(OFS_RAW_STATUS, 32'h00000000);
        wr(OFS_DOMAIN_RST, DATA_W'(1 << BIT_MAIN_RST));
        repeat (4) begin
            @(posedge clk_sys_in);
            #1 chk_idle();
        end
        wr(OFS_DOMAIN_RST, 32'h00000000);
        wr(OFS_RASTER_CTRL, 32'h00000001);
        chk_reg(OFS_RASTER_CTRL, 32'h00000001);
        // second recovery path: dma and core resets instead of main
        wr(OFS_RASTER_CTRL, 32'h00000000);
        wait_done(10);
        wr(OFS_DOMAIN_RST, DATA_W'((1 << BIT_DMA_RST) | (1 << BIT_CORE_RST)));
        wr(OFS_RASTER_CTRL, 32'h00000001);
        wr(OFS_RAW_STATUS, 32'h00000003);
        repeat (3) @(posedge clk_sys_in);
        chk_reg(OFS_RAW_STATUS, 32'h00000000);
        chk_reg(OFS_FIFO_STATE, EMPTY);
        wr(OFS_DOMAIN_RST, 32'h00000000);
        repeat (3) @(posedge clk_sys_in);
        rd(OFS_RAW_STATUS);
        `CHK(d[BIT_UFLOW], 1'b1)
        wr(OFS_RASTER_CTRL, 32'h00000000);
        wait_done(10);
        wr(OFS_RAW_STATUS, 32'h00000003);
        $display("test raster_recovery done");
    endtask

    // an aborted transfer leaves its last fetched word to the raster side
    task automatic test_raster_pixel();
        int pulses;
        pulses = 0;
        model_clear(8'hff, 1'b0);
        wr(OFS_RASTER_CTRL, 32'h00000001);
        wr(OFS_DMA_LENGTH, 32'h00000008);
        wr(OFS_ASYNC_CTRL, 32'h00000001);
        wr(OFS_ASYNC_CTRL, 32'h00000000);
        repeat (4) begin
            @(posedge clk_sys_in);
            #1;
            if (pixel_valid_out === 1'b1) begin
                pulses++;
                `CHK(panel_data_out, 32'ha5a50000 | DATA_W'(words_seen))
            end
        end
        `CHK(pulses, 1)
        `CHK(words_seen, 8'h01)
        `CHK(order_ok, 1'b1)
        wr(OFS_RASTER_CTRL, 32'h00000000);
        wait_done(10);
        wr(OFS_RAW_STATUS, 32'h00000003);
        $display("test raster_pixel done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // whole run is well under a thousand cycles; this span leaves ample margin
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst_in       = 1'b1;
        reg_addr_in  = 8'h00;
        reg_wdata_in = 32'h00000000;
        reg_wr_in    = 1'b0;
        reg_rd_in    = 1'b0;
        clear        = 1'b1;
        slow         = 1'b0;
        limit        = 8'h00;
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        clear  <= 1'b0;
        test_reset_values();
        test_dma_done();
        test_soft_reset();
        test_raster_recovery();
        test_raster_pixel();
        finish_test();
    end
endmodule
